/* burner_far_side.sv */
/*
 Far side model: burner, interlocks and flame detector.
 Assumes the bench sets the switch knobs and that drive_out comes
 from the sequencer.
*/
`timescale 1ns/100ps
`default_nettype none
module burner_far_side #(
    parameter int LIGHT = 4
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // knobs from the bench
    input wire logic [5:0] switches,
    input wire logic fuel_ok,
    input wire logic stray_flame,
    // sequencer side
    input wire burner_pkg::outs_t drive_out,
    output var burner_pkg::pins_t pins_out
);
    import burner_pkg::*;

    // ----------------------------------------------------------------
    // flame detector
    // ----------------------------------------------------------------
    logic [3:0] lit_cnt;
    logic [3:0] next_lit_cnt;
    logic fueled;

    assign fueled = fuel_ok & drive_out.blower & (drive_out.ign_short
        | drive_out.ign_long | drive_out.main_valve);

    // flame takes a few cycles to light, dies at once without fuel
    always_comb begin
        next_lit_cnt = 4'h0;
        if (fueled) begin
            next_lit_cnt = (lit_cnt == 4'(LIGHT)) ? lit_cnt : lit_cnt + 4'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lit_cnt <= 4'h0;
        end else begin
            lit_cnt <= next_lit_cnt;
        end
    end

    assign pins_out = {switches,
        stray_flame | (fueled && lit_cnt == 4'(LIGHT))};
endmodule
`default_nettype wire

/* burner_pkg.sv */
/*
 Constants and types shared by the burner safety sequencer.
 Assumes a 250 MHz pclk and an APB master with 32-bit data.
*/
// Contract
// - call, limits and preignition closed, no flame: load relay, timer, blower
// - at 4 s drive firing-rate motor to high fire
// - from 4 s the timer runs without the load relay
// - at 9.5 s open airflow proof drops load relay, no trial
// - running interlock opening until run end shuts down, timer finishes
// - flame accepted from 15 s; flame before 57.5 s shuts down
// - at 45 s drive firing-rate motor to low fire
// - at 52 s wait for low fire and timer switches until 66 s
// - at 57.5 s heat lockout heater, ignore preignition interlocks
// - at 60 s ignition and pilot on, or main valve if direct spark
// - flame during trial pulls flame relay and stops heater
// - at 70 s without flame relay: safety shutdown and lockout
// - at 70 s with flame proven open main fuel valve
// - after 70 s flame relay may not newly pull in
// - short pilot/ignition output off at 80 s
// - first variant: long pilot/ignition off at 100 s
// - second variant: long pilot/ignition off at 85 s
// - at 100 s firing rate released to external modulation
// - at 104 s timer halts in run while burner fires
// - call withdrawn: load relay and main valve off, postpurge starts
// - modulation ends at 112 s, low fire drive at 116 s
// - at 120 s timer and blower stop, back to standby
package burner_pkg;

    // ----------------------------------------------------------------
    // time base
    // ----------------------------------------------------------------
    localparam int CLK_HZ = 250_000_000;
    localparam int TICK_MS = 500;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

    // ----------------------------------------------------------------
    // event times, ms, and their tick positions
    // ----------------------------------------------------------------
    localparam int T_HIGH_MS = 4000;
    localparam int T_AIR_MS = 9500;
    localparam int T_FLAME_MS = 15000;
    localparam int T_LOW_MS = 45000;
    localparam int T_LFCHK_MS = 52000;
    localparam int T_HTR_MS = 57500;
    localparam int T_TRIAL_MS = 60000;
    localparam int T_BYPASS_MS = 66000;
    localparam int T_TEND_MS = 70000;
    localparam int T_SHORT_MS = 80000;
    localparam int T_LONGB_MS = 85000;
    localparam int T_LONGA_MS = 100000;
    localparam int T_MOD_MS = 100000;
    localparam int T_RUN_MS = 104000;
    localparam int T_MODX_MS = 112000;
    localparam int T_PLOW_MS = 116000;
    localparam int T_END_MS = 120000;

    localparam logic [7:0] P_HIGH = 8'(T_HIGH_MS / TICK_MS);
    localparam logic [7:0] P_AIR = 8'(T_AIR_MS / TICK_MS);
    localparam logic [7:0] P_FLAME = 8'(T_FLAME_MS / TICK_MS);
    localparam logic [7:0] P_LOW = 8'(T_LOW_MS / TICK_MS);
    localparam logic [7:0] P_LFCHK = 8'(T_LFCHK_MS / TICK_MS);
    localparam logic [7:0] P_HTR = 8'(T_HTR_MS / TICK_MS);
    localparam logic [7:0] P_TRIAL = 8'(T_TRIAL_MS / TICK_MS);
    localparam logic [7:0] P_BYPASS = 8'(T_BYPASS_MS / TICK_MS);
    localparam logic [7:0] P_TEND = 8'(T_TEND_MS / TICK_MS);
    localparam logic [7:0] P_SHORT = 8'(T_SHORT_MS / TICK_MS);
    localparam logic [7:0] P_LONGB = 8'(T_LONGB_MS / TICK_MS);
    localparam logic [7:0] P_LONGA = 8'(T_LONGA_MS / TICK_MS);
    localparam logic [7:0] P_MOD = 8'(T_MOD_MS / TICK_MS);
    localparam logic [7:0] P_RUN = 8'(T_RUN_MS / TICK_MS);
    localparam logic [7:0] P_MODX = 8'(T_MODX_MS / TICK_MS);
    localparam logic [7:0] P_PLOW = 8'(T_PLOW_MS / TICK_MS);
    localparam logic [7:0] P_END = 8'(T_END_MS / TICK_MS);

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam int CTRL_DIRECT = 0;
    localparam int CTRL_LONGB = 1;
    localparam int CTRL_UNLOCK = 2;
    localparam logic CTRL_DIRECT_RST = 1'h0;
    localparam logic CTRL_LONGB_RST = 1'h0;
    localparam int ST_LOAD = 8;
    localparam int ST_FLAME = 9;
    localparam int ST_LOCK = 10;
    localparam int ST_RUNS = 11;
    localparam int ST_CYC = 12;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {STANDBY, CYCLE, LOCKOUT} seq_state_t;

    typedef struct packed {
        logic call_heat;
        logic limits_ok;
        logic preign_ok;
        logic running_ok;
        logic low_fire_ok;
        logic timer_sw_ok;
        logic flame_sense;
    } pins_t;

    typedef struct packed {
        logic load_relay;
        logic flame_relay;
        logic blower;
        logic fire_high;
        logic fire_low;
        logic modulate;
        logic ign_short;
        logic ign_long;
        logic main_valve;
        logic lockout_heater;
        logic lockout_contact;
    } outs_t;

endpackage

/* burner_safety_sequencer.sv */
/*
 Burner safety sequencer: 120 s cycle with prepurge, trial, run and
 postpurge, plus an APB slave for options and status.
 Assumes pin inputs are asynchronous to pclk and that an APB master
 drives the register side.
*/
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module burner_safety_sequencer #(
    parameter int TICK_CYCLES = burner_pkg::TICK_CYCLES
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output var logic [31:0] prdata,
    output var logic pready,
    output var logic pslverr,
    // burner pins
    input wire burner_pkg::pins_t pins_in,
    output var burner_pkg::outs_t drive_out
);
    import burner_pkg::*;

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    pins_t sync1;
    pins_t pin;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1 <= '0;
            pin <= '0;
        end else begin
            sync1 <= pins_in;
            pin <= sync1;
        end
    end

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    seq_state_t st;
    seq_state_t next_st;
    logic [7:0] pos;
    logic [7:0] next_pos;
    logic [31:0] presc;
    logic [31:0] next_presc;
    logic load;
    logic next_load;
    logic flame;
    logic next_flame;
    logic direct;
    logic next_direct;
    logic long_b;
    logic next_long_b;
    logic [31:0] next_prdata;
    outs_t next_o;
    logic hold_lf;
    logic hold_run;
    logic run_ok;
    logic tick;
    logic wr;
    logic unlock;
    logic mapped;

    // ----------------------------------------------------------------
    // timer permission and tick
    // ----------------------------------------------------------------
    always_comb begin
        hold_lf = pos >= P_LFCHK && pos < P_BYPASS
                  && (!pin.low_fire_ok || !pin.timer_sw_ok);
        hold_run = pos == P_RUN && load;
        run_ok = st == CYCLE && !hold_lf && !hold_run
                 && (load || pos >= P_HIGH);
        tick = run_ok && presc == 32'(TICK_CYCLES - 1);
    end

    // ----------------------------------------------------------------
    // sequence next state
    // ----------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_pos = pos;
        next_presc = presc;
        next_load = load;
        unique case (st)
            STANDBY: begin
                next_pos = 8'h00;
                next_presc = 32'h0;
                if (pin.call_heat && pin.limits_ok && pin.preign_ok
                    && !flame) begin
                    next_st = CYCLE;
                    next_load = 1'b1;
                end
            end
            CYCLE: begin
                if (tick) begin
                    next_presc = 32'h0;
                    next_pos = pos + 8'h01;
                end else if (run_ok) begin
                    next_presc = presc + 32'h1;
                end
                if (!pin.call_heat || !pin.limits_ok) begin
                    next_load = 1'b0;
                end
                if (pos < P_HTR && !pin.preign_ok) begin
                    next_load = 1'b0;
                end
                if (pos >= P_AIR && pos <= P_RUN && !pin.running_ok) begin
                    next_load = 1'b0;
                end
                if (pos >= P_FLAME && pos < P_HTR && flame) begin
                    next_load = 1'b0;
                end
                if (!load && pos < P_HIGH) begin
                    next_st = STANDBY;
                    next_load = 1'b0;
                end
                if (pos == P_TEND && load && !flame) begin
                    next_st = LOCKOUT;
                    next_load = 1'b0;
                end
                if (pos == P_END) begin
                    next_st = STANDBY;
                    next_load = 1'b0;
                end
            end
            LOCKOUT: begin
                next_load = 1'b0;
                next_presc = 32'h0;
                if (unlock) begin
                    next_st = STANDBY;
                    next_pos = 8'h00;
                end
            end
            default: begin
                next_st = STANDBY;
                next_load = 1'b0;
            end
        endcase
        next_flame = pin.flame_sense
                     && (flame || (st == CYCLE && pos >= P_FLAME
                     && pos < P_TEND));
    end

    // ----------------------------------------------------------------
    // output decode
    // ----------------------------------------------------------------
    always_comb begin
        next_o = '0;
        next_o.flame_relay = next_flame;
        next_o.fire_low = 1'b1;
        unique case (st)
            CYCLE: begin
                next_o.blower = 1'b1;
                next_o.fire_high = pos >= P_HIGH && pos < P_LOW;
                next_o.fire_low = pos < P_HIGH
                    || (pos >= P_LOW && pos < P_MOD)
                    || pos >= P_PLOW;
                next_o.modulate = pos >= P_MOD && pos < P_MODX;
                next_o.load_relay = next_load;
                if (load) begin
                    next_o.lockout_heater = pos >= P_HTR
                        && pos < P_TEND && !flame;
                    next_o.ign_short = pos >= P_TRIAL
                        && pos < P_SHORT;
                    next_o.ign_long = pos >= P_TRIAL
                        && pos < (long_b ? P_LONGB : P_LONGA);
                    next_o.main_valve = (direct && pos >= P_TRIAL)
                        || (flame && pos >= P_TEND);
                end
                if (!next_load) begin
                    next_o.main_valve = 1'b0;
                end
            end
            LOCKOUT: begin
                next_o.lockout_contact = 1'b1;
            end
            default: begin
                next_o.load_relay = 1'b0;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    always_comb begin
        wr = psel && penable && pwrite;
        mapped = paddr == ADDR_CTRL || paddr == ADDR_STATUS;
        unlock = wr && paddr == ADDR_CTRL && pwdata[CTRL_UNLOCK];
        next_direct = direct;
        next_long_b = long_b;
        if (wr && paddr == ADDR_CTRL) begin
            next_direct = pwdata[CTRL_DIRECT];
            next_long_b = pwdata[CTRL_LONGB];
        end
        next_prdata = prdata;
        if (psel && !penable) begin
            next_prdata = 32'h0;
            if (paddr == ADDR_CTRL) begin
                next_prdata[CTRL_DIRECT] = direct;
                next_prdata[CTRL_LONGB] = long_b;
            end else if (paddr == ADDR_STATUS) begin
                next_prdata[7:0] = pos;
                next_prdata[ST_LOAD] = load;
                next_prdata[ST_FLAME] = flame;
                next_prdata[ST_LOCK] = st == LOCKOUT;
                next_prdata[ST_RUNS] = run_ok;
                next_prdata[ST_CYC] = st == CYCLE;
            end
        end
        pready = 1'b1;
        pslverr = psel && penable && !mapped;
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= STANDBY;
            pos <= 8'h00;
            presc <= 32'h0;
            load <= 1'b0;
            flame <= 1'b0;
            direct <= CTRL_DIRECT_RST;
            long_b <= CTRL_LONGB_RST;
            prdata <= 32'h0;
            drive_out <= '0;
        end else begin
            st <= next_st;
            pos <= next_pos;
            presc <= next_presc;
            load <= next_load;
            flame <= next_flame;
            direct <= next_direct;
            long_b <= next_long_b;
            prdata <= next_prdata;
            drive_out <= next_o;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_start;
        st == STANDBY && pin.call_heat && pin.limits_ok
            && pin.preign_ok && !flame
            |=> st == CYCLE && load ##1 drive_out.blower;
    endproperty
    a_start: assert property (p_start)
        else $error("start check did not start the cycle");

    property p_high;
        st == CYCLE && pos >= P_HIGH && pos < P_LOW
            |=> drive_out.fire_high && !drive_out.fire_low;
    endproperty
    a_high: assert property (p_high)
        else $error("no high fire drive in prepurge");

    property p_low;
        st == CYCLE && pos >= P_LOW && pos < P_MOD
            |=> drive_out.fire_low && !drive_out.fire_high;
    endproperty
    a_low: assert property (p_low)
        else $error("no low fire drive after 45 s");

    property p_air;
        st == CYCLE && pos >= P_AIR && pos <= P_RUN
            && !pin.running_ok |=> !load ##1 !drive_out.load_relay;
    endproperty
    a_air: assert property (p_air)
        else $error("airflow loss kept the load relay");

    property p_preflame;
        st == CYCLE && pos >= P_FLAME && pos < P_HTR && flame
            |=> !load;
    endproperty
    a_preflame: assert property (p_preflame)
        else $error("early flame did not shut down");

    property p_lfhold;
        st == CYCLE && pos == P_LFCHK && !pin.low_fire_ok
            |=> $stable(pos) && !$past(tick);
    endproperty
    a_lfhold: assert property (p_lfhold)
        else $error("timer moved without low fire proof");

    property p_lock;
        st == CYCLE && pos == P_TEND && load && !flame
            |=> st == LOCKOUT ##1 drive_out.lockout_contact
            && !drive_out.main_valve;
    endproperty
    a_lock: assert property (p_lock)
        else $error("failed trial did not lock out");

    property p_main;
        st == CYCLE && load && flame && next_load && pos >= P_TEND
            |=> drive_out.main_valve;
    endproperty
    a_main: assert property (p_main)
        else $error("main valve closed with flame proven");

    property p_noflame;
        pos >= P_TEND && !flame |=> !flame;
    endproperty
    a_noflame: assert property (p_noflame)
        else $error("flame relay pulled in after trial");

    property p_short;
        pos >= P_SHORT && st == CYCLE |=> !drive_out.ign_short;
    endproperty
    a_short: assert property (p_short)
        else $error("short ignition still on after 80 s");

    property p_trial;
        st == CYCLE && load && pos >= P_TRIAL && pos < P_SHORT
            |=> drive_out.ign_short;
    endproperty
    a_trial: assert property (p_trial)
        else $error("no ignition in the trial");

    property p_heat;
        st == CYCLE && flame |=> !drive_out.lockout_heater;
    endproperty
    a_heat: assert property (p_heat)
        else $error("lockout heater on with flame proven");

    property p_drop;
        st == CYCLE && !pin.call_heat
            |=> !load ##1 !drive_out.main_valve;
    endproperty
    a_drop: assert property (p_drop)
        else $error("call withdrawn but fuel kept");

    property p_mod;
        st == CYCLE && pos >= P_MOD && pos < P_MODX
            |=> drive_out.modulate && !drive_out.fire_low;
    endproperty
    a_mod: assert property (p_mod)
        else $error("no modulation after 100 s");

    property p_run;
        st == CYCLE && pos == P_RUN && load
            |=> pos == P_RUN && presc == $past(presc);
    endproperty
    a_run: assert property (p_run)
        else $error("timer ran during the run period");

    property p_end;
        st == CYCLE && pos == P_END |=> st == STANDBY
            ##1 !drive_out.blower;
    endproperty
    a_end: assert property (p_end)
        else $error("cycle did not end at 120 s");

    c_run: cover property (st == CYCLE && pos == P_RUN && load);
    c_lock: cover property (st == LOCKOUT);
    c_post: cover property (st == CYCLE && pos > P_RUN && !load);
    c_end: cover property (st == CYCLE && pos == P_END);

endmodule
`default_nettype wire

/* burner_safety_sequencer_test.sv */
/*
 Self-checking bench for the burner safety sequencer.
 Assumes burner_pkg and the far side model are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, x) begin n_checks++; if ((g) !== (x)) begin n_errors++; \
    $display("[FAIL] t=%0t got=%0h exp=%0h", $time, g, x); end end
module burner_safety_sequencer_test;
    import burner_pkg::*;

    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    localparam int TICK = 8;
    localparam outs_t IDLE = '{fire_low: 1'b1, default: 1'b0};
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [5:0] sw = 6'h00;
    logic fuel_ok = 1'b1;
    logic stray = 1'b0;
    pins_t pins;
    outs_t drive_out;
    logic [31:0] s;
    logic e;
    int n_errors = 0;
    int n_checks = 0;

    always #2 pclk = ~pclk;

    burner_safety_sequencer #(.TICK_CYCLES(TICK)) dut (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pins_in(pins), .drive_out(drive_out));

    burner_far_side far (.pclk(pclk), .presetn(presetn), .switches(sw),
        .fuel_ok(fuel_ok), .stray_flame(stray), .drive_out(drive_out),
        .pins_out(pins));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic complete_run();
        $display("checks=%0d errors=%0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic hang();
        n_errors++;
        $display("[FAIL] t=%0t got=%0h exp=%0h", $time, 0, 1);
        complete_run();
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) begin
                break;
            end
        end
        if (i == 50) begin
            hang();
        end
        s = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic settle();
        repeat (3) @(posedge pclk);
        #1;
    endtask

    task automatic wait_pos(input int p);
        int i;
        for (i = 0; i < 3000; i++) begin
            apb(1'b0, ADDR_STATUS, 32'h0);
            if (s[7:0] >= p) begin
                break;
            end
        end
        if (i == 3000) begin
            hang();
        end
    endtask

    task automatic wait_idle();
        int i;
        for (i = 0; i < 3000; i++) begin
            apb(1'b0, ADDR_STATUS, 32'h0);
            if (s[ST_CYC] === 1'b0) begin
                break;
            end
        end
        if (i == 3000) begin
            hang();
        end
        settle();
    endtask

    function automatic outs_t model(int p, logic ld, fl, dr, lb);
        outs_t o;
        o = '0;
        o.load_relay = ld;
        o.flame_relay = fl;
        o.blower = p < 240;
        o.fire_high = p >= 8 && p < 90;
        o.fire_low = p < 8 || (p >= 90 && p < 200) || p >= 232;
        o.modulate = p >= 200 && p < 224;
        o.lockout_heater = p >= 115 && p < 140 && !fl;
        o.ign_short = ld && p >= 120 && p < 160;
        o.ign_long = ld && p >= 120 && p < (lb ? 170 : 200);
        o.main_valve = ld && ((dr && p >= 120) || (fl && p >= 140));
        return o;
    endfunction

    task automatic at_pos(input int p, input logic dr, lb);
        wait_pos(p);
        settle();
        `CHK(drive_out, model(p, 1'b1, p >= 122, dr, lb))
    endtask

    task automatic hold_at(input int p);
        repeat (5 * TICK) @(posedge pclk);
        apb(1'b0, ADDR_STATUS, 32'h0);
        `CHK(s[7:0], 8'(p))
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_regs();
        `CHK(drive_out, IDLE)
        apb(1'b0, ADDR_CTRL, 32'h0);
        `CHK(s, 32'h0)
        apb(1'b1, ADDR_CTRL, 32'h3);
        apb(1'b0, ADDR_CTRL, 32'h0);
        `CHK(s, 32'h3)
        apb(1'b1, ADDR_STATUS, 32'hFFFF_FFFF);
        `CHK(e, 1'b0)
        apb(1'b0, ADDR_STATUS, 32'h0);
        `CHK(s[7:0], 8'h00)
        apb(1'b0, 8'h08, 32'h0);
        `CHK({e, s}, {1'b1, 32'h0})
        apb(1'b1, ADDR_CTRL, 32'h0);
        $display("test regs done");
    endtask

    task automatic t_normal();
        int pts[10] = '{2, 10, 86, 92, 116, 122, 142, 162, 172, 202};
        sw <= 6'b111101;
        for (int i = 0; i < 4; i++) begin
            at_pos(pts[i], 1'b0, 1'b0);
        end
        wait_pos(P_LFCHK);
        hold_at(P_LFCHK);
        sw[1] <= 1'b1;
        for (int i = 4; i < 10; i++) begin
            at_pos(pts[i], 1'b0, 1'b0);
        end
        wait_pos(P_RUN);
        hold_at(P_RUN);
        sw[5] <= 1'b0;
        settle();
        `CHK({drive_out.load_relay, drive_out.main_valve}, 2'b00)
        wait_pos(P_RUN + 4);
        for (int p = 226; p < 240; p += 8) begin
            wait_pos(p);
            settle();
            `CHK(drive_out, model(p, 1'b0, 1'b0, 1'b0, 1'b0))
        end
        wait_idle();
        `CHK(drive_out, IDLE)
        $display("test normal done");
    endtask

    task automatic t_variant();
        apb(1'b1, ADDR_CTRL, 32'h3);
        sw <= 6'b111110;
        wait_pos(P_LFCHK);
        hold_at(P_LFCHK);
        sw[0] <= 1'b1;
        at_pos(122, 1'b1, 1'b1);
        at_pos(172, 1'b1, 1'b1);
        wait_pos(P_RUN);
        sw[5] <= 1'b0;
        wait_idle();
        apb(1'b1, ADDR_CTRL, 32'h0);
        $display("test variant done");
    endtask

    task automatic t_airflow();
        sw <= 6'b111011;
        wait_pos(22);
        settle();
        `CHK(drive_out.load_relay, 1'b0)
        `CHK(drive_out.blower, 1'b1)
        wait_pos(122);
        settle();
        `CHK({drive_out.ign_short, drive_out.ign_long}, 2'b00)
        `CHK(drive_out.main_valve, 1'b0)
        sw <= 6'b011111;
        wait_idle();
        `CHK(drive_out, IDLE)
        $display("test airflow done");
    endtask

    task automatic t_flame();
        sw <= 6'b111111;
        wait_pos(40);
        stray <= 1'b1;
        settle();
        settle();
        `CHK(drive_out.flame_relay, 1'b1)
        `CHK(drive_out.load_relay, 1'b0)
        sw[5] <= 1'b0;
        wait_idle();
        sw[5] <= 1'b1;
        repeat (20) @(posedge pclk);
        #1;
        `CHK({drive_out.flame_relay, drive_out.load_relay}, 2'b10)
        stray <= 1'b0;
        settle();
        settle();
        `CHK({drive_out.load_relay, drive_out.blower}, 2'b11)
        sw[5] <= 1'b0;
        wait_idle();
        $display("test flame done");
    endtask

    task automatic t_lockout();
        fuel_ok <= 1'b0;
        sw <= 6'b111111;
        wait_pos(P_TEND);
        settle();
        `CHK({drive_out.lockout_contact, drive_out.load_relay}, 2'b10)
        `CHK({drive_out.ign_short, drive_out.main_valve}, 2'b00)
        stray <= 1'b1;
        settle();
        settle();
        `CHK(drive_out.flame_relay, 1'b0)
        stray <= 1'b0;
        sw[5] <= 1'b0;
        fuel_ok <= 1'b1;
        apb(1'b1, ADDR_CTRL, 32'h4);
        settle();
        apb(1'b0, ADDR_STATUS, 32'h0);
        `CHK({drive_out.lockout_contact, s[ST_LOCK]}, 2'b00)
        $display("test lockout done");
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        settle();
        t_regs();
        t_normal();
        t_variant();
        t_airflow();
        t_flame();
        t_lockout();
        complete_run();
    end
endmodule
`default_nettype wire
